// File: cdtd_core.sv
// Decode and execute core for the move and exchange instruction group.
// Assumes a memory bus with reads answered exactly one cycle after request.
//
// Contract
// - Eight byte registers, index 0..7 are X, A, C, B, E, D, L, H.
// - Four pairs, index 0..3: wide accumulator, pair one, pair two, index.
// - Short direct operands lie in FE20H..FF1FH; word form even only.
// - Absolute operands span 0000H..FFFFH; word transfers need even address.
// - Call-table operand must be even within 0040H..007FH.
// - Bit number is three bits and selects one of eight bits.
// - Branch offset is signed 8-bit, sign-extended then added to PC.
// - Byte accumulator A, and wide accumulator pairing A with X.
// - Each flag is kept, cleared, set, from result or restored; the core selects only keep and from result, never clear, set or restore.
// - Immediate byte moves: three bytes, six clocks, flags unchanged.
// - Accumulator to or from absolute address: three bytes, eight clocks.
// - Writing status word replaces flags; reading it keeps flags.
// - Based moves through index pair plus offset: two bytes, six clocks.
// - Swap of A with X: one byte, four clocks.
// - Swap A with register or location: two bytes, six; not A or X.
// - Swap A with indirect memory: one byte, eight clocks.
// - Swap A with based memory: two bytes, eight clocks.
`timescale 1ns/1ps
`include "cdtd_defs.svh"
module cdtd_core
    import cdtd_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Instruction request.
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire cdtd_req_s   req,
    input  wire logic [7:0]  flags_saved,
    // Completion.
    output logic             done_q,
    output logic [1:0]       len_q,
    output logic             err_q,
    // Memory and special register bus.
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata,
    // Architectural state.
    output logic [7:0]       acc,
    output logic [15:0]      wide_accumulator,
    output logic [7:0]       program_status_word,
    // Operand checks.
    input  wire cdtd_chk_s   chk,
    output logic             chk_ok_q,
    output logic [7:0]       bit_mask_q,
    output logic [15:0]      branch_target_q
);
    typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_EXEC = 2'h2} cdtd_st_e;

    function automatic cdtd_info_s op_info(input cdtd_op_e op);
        cdtd_info_s i;
        i = '{len: 2'h2, clocks: `CDTD_CLK4, rd: 1'b0, wr: 1'b0};
        unique case (op)
            OP_XFER_R_IMM, OP_XFER_STAT_IMM:
                i = '{2'h3, `CDTD_CLK6, 1'b0, 1'b0};
            OP_XFER_SADDR_IMM, OP_XFER_SFR_IMM:
                i = '{2'h3, `CDTD_CLK6, 1'b0, 1'b1};
            OP_XFER_A_R, OP_XFER_R_A, OP_XFER_A_STAT, OP_XFER_STAT_A:
                i = '{2'h2, `CDTD_CLK4, 1'b0, 1'b0};
            OP_XFER_A_SADDR, OP_XFER_A_SFR:
                i = '{2'h2, `CDTD_CLK4, 1'b1, 1'b0};
            OP_XFER_SADDR_A, OP_XFER_SFR_A:
                i = '{2'h2, `CDTD_CLK4, 1'b0, 1'b1};
            OP_XFER_A_ABS: i = '{2'h3, `CDTD_CLK8, 1'b1, 1'b0};
            OP_XFER_ABS_A: i = '{2'h3, `CDTD_CLK8, 1'b0, 1'b1};
            OP_XFER_A_IND: i = '{2'h1, `CDTD_CLK6, 1'b1, 1'b0};
            OP_XFER_IND_A: i = '{2'h1, `CDTD_CLK6, 1'b0, 1'b1};
            OP_XFER_A_BASED: i = '{2'h2, `CDTD_CLK6, 1'b1, 1'b0};
            OP_XFER_BASED_A: i = '{2'h2, `CDTD_CLK6, 1'b0, 1'b1};
            OP_SWAP_A_X: i = '{2'h1, `CDTD_CLK4, 1'b0, 1'b0};
            OP_SWAP_A_R: i = '{2'h2, `CDTD_CLK6, 1'b0, 1'b0};
            OP_SWAP_A_SADDR, OP_SWAP_A_SFR:
                i = '{2'h2, `CDTD_CLK6, 1'b1, 1'b1};
            OP_SWAP_A_IND: i = '{2'h1, `CDTD_CLK8, 1'b1, 1'b1};
            OP_SWAP_A_BASED: i = '{2'h2, `CDTD_CLK8, 1'b1, 1'b1};
            default: i = '{2'h2, `CDTD_CLK4, 1'b0, 1'b0};
        endcase
        return i;
    endfunction

    function automatic logic flag_next(input cdtd_fmode_e m, input logic cur,
                                       input logic res, input logic sav);
        logic f;
        f = cur;
        unique case (m)
            FM_KEEP:    f = cur;
            FM_CLR:     f = 1'b0;
            FM_SET:     f = 1'b1;
            FM_RESULT:  f = res;
            FM_RESTORE: f = sav;
            default:    f = cur;
        endcase
        return f;
    endfunction

    cdtd_st_e    st_q, st_d;
    cdtd_req_s   ins_q, ins_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [15:0] ea_q, ea_d;
    logic [7:0]  rd_q, rd_d;
    logic [7:0]  regs_q [8];
    logic [7:0]  regs_d [8];
    logic [7:0]  stat_q, stat_d;
    logic        done_d, err_d;
    logic [1:0]  len_d;
    logic        accept, illegal, commit, in_saddr;
    logic [15:0] pair_val;
    cdtd_fmode_e fm;
    cdtd_info_s  inf;
    logic [7:0]  stat_src;

    assign req_ready = (st_q == ST_IDLE);
    assign accept    = req_valid && req_ready;
    assign commit    = (st_q == ST_EXEC) && (cnt_q == 4'h1);
    assign inf       = op_info(ins_q.op);
    assign in_saddr  = (req.addr >= `CDTD_SADDR_LO) &&
                       (req.addr <= `CDTD_SADDR_HI);
    // Pair p is high register 2p+1 over low register 2p.
    assign pair_val  = {regs_q[{req.pair_idx, 1'b1}],
                        regs_q[{req.pair_idx, 1'b0}]};
    assign acc              = regs_q[`CDTD_REG_A];
    assign wide_accumulator = {regs_q[`CDTD_REG_A],
                               regs_q[`CDTD_REG_X]};
    assign program_status_word = stat_q;

    always_comb begin
        illegal = 1'b0;
        unique case (req.op)
            OP_XFER_A_R, OP_XFER_R_A:
                illegal = (req.reg_idx == `CDTD_REG_A);
            OP_SWAP_A_R:
                illegal = (req.reg_idx == `CDTD_REG_A) ||
                          (req.reg_idx == `CDTD_REG_X);
            OP_XFER_SADDR_IMM, OP_XFER_A_SADDR, OP_XFER_SADDR_A,
            OP_SWAP_A_SADDR:
                illegal = !in_saddr;
            OP_XFER_A_IND, OP_XFER_IND_A, OP_SWAP_A_IND:
                illegal = (req.pair_idx != `CDTD_PAIR_TWO) &&
                          (req.pair_idx != `CDTD_PAIR_IDX);
            default: illegal = 1'b0;
        endcase
    end

    // Sequencer: effective address, cycle count, read capture.
    always_comb begin
        st_d   = st_q;
        ins_d  = ins_q;
        cnt_d  = cnt_q;
        ea_d   = ea_q;
        rd_d   = rd_q;
        done_d = 1'b0;
        err_d  = 1'b0;
        len_d  = len_q;
        unique case (st_q)
            ST_IDLE: begin
                if (accept && illegal) begin
                    err_d = 1'b1;
                end else if (accept) begin
                    st_d  = ST_EXEC;
                    ins_d = req;
                    cnt_d = op_info(req.op).clocks - 4'h1;
                    unique case (req.op)
                        OP_XFER_SFR_IMM, OP_XFER_A_SFR, OP_XFER_SFR_A,
                        OP_SWAP_A_SFR:
                            ea_d = {`CDTD_SFR_BASE, req.addr[7:0]};
                        OP_XFER_A_IND, OP_XFER_IND_A, OP_SWAP_A_IND:
                            ea_d = pair_val;
                        OP_XFER_A_BASED, OP_XFER_BASED_A, OP_SWAP_A_BASED:
                            ea_d = {regs_q[7], regs_q[6]} +
                                   {8'h00, req.imm};
                        default: ea_d = req.addr;
                    endcase
                end
            end
            ST_EXEC: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == inf.clocks - 4'h2) begin
                    rd_d = mem_rdata;
                end
                if (commit) begin
                    st_d   = ST_IDLE;
                    done_d = 1'b1;
                    len_d  = inf.len;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_comb begin
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = ea_q;
        mem_wdata = regs_q[`CDTD_REG_A];
        if (st_q == ST_EXEC) begin
            if (inf.rd && cnt_q == inf.clocks - 4'h1) begin
                mem_req = 1'b1;
            end
            if (inf.wr && commit) begin
                mem_req = 1'b1;
                mem_we  = 1'b1;
            end
        end
        if (ins_q.op == OP_XFER_SADDR_IMM || ins_q.op == OP_XFER_SFR_IMM) begin
            mem_wdata = ins_q.imm;
        end
    end

    // Architectural state changes only on the commit cycle.
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            regs_d[k] = regs_q[k];
        end
        stat_d   = stat_q;
        stat_src = ins_q.imm;
        fm       = FM_KEEP;
        if (commit) begin
            unique case (ins_q.op)
                OP_XFER_R_IMM: regs_d[ins_q.reg_idx] = ins_q.imm;
                OP_XFER_A_R:
                    regs_d[`CDTD_REG_A] = regs_q[ins_q.reg_idx];
                OP_XFER_R_A:
                    regs_d[ins_q.reg_idx] = regs_q[`CDTD_REG_A];
                OP_XFER_A_SADDR, OP_XFER_A_SFR, OP_XFER_A_ABS,
                OP_XFER_A_IND, OP_XFER_A_BASED,
                OP_SWAP_A_SADDR, OP_SWAP_A_SFR, OP_SWAP_A_IND,
                OP_SWAP_A_BASED:
                    regs_d[`CDTD_REG_A] = rd_q;
                OP_XFER_A_STAT: regs_d[`CDTD_REG_A] = stat_q;
                OP_XFER_STAT_IMM: fm = FM_RESULT;
                OP_XFER_STAT_A: begin
                    fm       = FM_RESULT;
                    stat_src = regs_q[`CDTD_REG_A];
                end
                // The A and X swap ignores the register field of the request.
                OP_SWAP_A_X: begin
                    regs_d[`CDTD_REG_A] = regs_q[`CDTD_REG_X];
                    regs_d[`CDTD_REG_X] = regs_q[`CDTD_REG_A];
                end
                OP_SWAP_A_R: begin
                    regs_d[`CDTD_REG_A]   = regs_q[ins_q.reg_idx];
                    regs_d[ins_q.reg_idx] = regs_q[`CDTD_REG_A];
                end
                default: fm = FM_KEEP;
            endcase
            if (fm != FM_KEEP) begin
                stat_d = stat_src;
            end
            stat_d[`CDTD_BIT_Z] = flag_next(fm, stat_q[`CDTD_BIT_Z],
                stat_src[`CDTD_BIT_Z], flags_saved[`CDTD_BIT_Z]);
            stat_d[`CDTD_BIT_AUX] = flag_next(fm, stat_q[`CDTD_BIT_AUX],
                stat_src[`CDTD_BIT_AUX], flags_saved[`CDTD_BIT_AUX]);
            stat_d[`CDTD_BIT_CARRY] = flag_next(fm, stat_q[`CDTD_BIT_CARRY],
                stat_src[`CDTD_BIT_CARRY], flags_saved[`CDTD_BIT_CARRY]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_IDLE;
            ins_q  <= '0;
            cnt_q  <= 4'h0;
            ea_q   <= 16'h0000;
            rd_q   <= 8'h00;
            done_q <= 1'b0;
            err_q  <= 1'b0;
            len_q  <= 2'h0;
            stat_q <= `CDTD_STAT_RST;
            for (int k = 0; k < 8; k++) begin
                regs_q[k] <= 8'h00;
            end
        end else begin
            st_q   <= st_d;
            ins_q  <= ins_d;
            cnt_q  <= cnt_d;
            ea_q   <= ea_d;
            rd_q   <= rd_d;
            done_q <= done_d;
            err_q  <= err_d;
            len_q  <= len_d;
            stat_q <= stat_d;
            for (int k = 0; k < 8; k++) begin
                regs_q[k] <= regs_d[k];
            end
        end
    end

    // Operand checks, registered one cycle after the query.
    logic        ok_d;
    logic [15:0] tgt_d;
    always_comb begin
        unique case (chk.kind)
            CK_SADDR:    ok_d = (chk.addr >= `CDTD_SADDR_LO) &&
                                (chk.addr <= `CDTD_SADDR_HI);
            CK_SADDRP:   ok_d = (chk.addr >= `CDTD_SADDR_LO) &&
                                (chk.addr <= `CDTD_SADDR_HI) &&
                                !chk.addr[0];
            CK_ABS:      ok_d = 1'b1;
            CK_ABS_WORD: ok_d = !chk.addr[0];
            CK_CALL:     ok_d = (chk.addr >= `CDTD_CALL_LO) &&
                                (chk.addr <= `CDTD_CALL_HI) &&
                                !chk.addr[0];
            default:     ok_d = 1'b0;
        endcase
        tgt_d = chk.pc + {{8{chk.branch_offset[7]}},
                          chk.branch_offset};
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chk_ok_q        <= 1'b0;
            bit_mask_q      <= 8'h00;
            branch_target_q <= 16'h0000;
        end else begin
            chk_ok_q        <= ok_d;
            bit_mask_q      <= 8'h01 << chk.bit_num;
            branch_target_q <= tgt_d;
        end
    end

    a_imm_six: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !illegal && req.op == OP_XFER_R_IMM
        |-> ##6 done_q && len_q == 2'h3) else $error("imm move timing");
    a_acc_reg_four: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !illegal && req.op == OP_XFER_A_R
        |-> ##4 done_q && len_q == 2'h2) else $error("reg move timing");
    a_acc_reject: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && req.op == OP_XFER_R_A && req.reg_idx == `CDTD_REG_A
        |=> err_q && req_ready) else $error("A not rejected");
    a_abs_eight: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && req.op == OP_XFER_A_ABS
        |-> ##8 done_q && len_q == 2'h3) else $error("abs move timing");
    a_stat_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        commit && ins_q.op == OP_XFER_A_STAT
        |=> $stable(stat_q) && acc == $past(stat_q))
        else $error("status read disturbed");
    a_ind_six: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !illegal && req.op == OP_XFER_IND_A
        |-> ##6 done_q && len_q == 2'h1) else $error("ind move timing");
    a_swap_x_four: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && req.op == OP_SWAP_A_X
        |-> ##4 done_q && len_q == 2'h1) else $error("swap x timing");
    a_swap_reg_six: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !illegal && req.op == OP_SWAP_A_R
        |-> ##6 done_q) else $error("swap reg timing");
    a_swap_ind_eight: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !illegal && req.op == OP_SWAP_A_IND
        |-> ##8 done_q) else $error("swap ind timing");
    a_busy_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        accept && !illegal |=> !req_ready [*3])
        else $error("early next instruction");
endmodule

// File: cdtd_defs.svh
// Constants of the data-transfer decoder: windows, cycle counts, fields.
// Assumes inclusion by the core only; the package does not include it.
`ifndef CDTD_DEFS_SVH
`define CDTD_DEFS_SVH
`define CDTD_SADDR_LO   16'hFE20
`define CDTD_SADDR_HI   16'hFF1F
`define CDTD_CALL_LO    16'h0040
`define CDTD_CALL_HI    16'h007F
`define CDTD_SFR_BASE   8'hFF
`define CDTD_REG_A      3'h1
`define CDTD_REG_X      3'h0
`define CDTD_PAIR_TWO   2'h2
`define CDTD_PAIR_IDX   2'h3
`define CDTD_BIT_Z      6
`define CDTD_BIT_AUX    4
`define CDTD_BIT_CARRY  0
`define CDTD_STAT_RST   8'h00
`define CDTD_CLK4       4'h4
`define CDTD_CLK6       4'h6
`define CDTD_CLK8       4'h8
`endif

// File: cdtd_pkg.sv
// Types of the data-transfer decoder: operations, flag modes, carriers.
// Assumes cdtd_defs.svh is on the include path.
package cdtd_pkg;
    typedef enum logic [4:0] {
        OP_XFER_R_IMM = 5'h00, OP_XFER_SADDR_IMM = 5'h01,
        OP_XFER_SFR_IMM = 5'h02, OP_XFER_A_R = 5'h03,
        OP_XFER_R_A = 5'h04, OP_XFER_A_SADDR = 5'h05,
        OP_XFER_SADDR_A = 5'h06, OP_XFER_A_SFR = 5'h07,
        OP_XFER_SFR_A = 5'h08, OP_XFER_A_ABS = 5'h09,
        OP_XFER_ABS_A = 5'h0A, OP_XFER_STAT_IMM = 5'h0B,
        OP_XFER_A_STAT = 5'h0C, OP_XFER_STAT_A = 5'h0D,
        OP_XFER_A_IND = 5'h0E, OP_XFER_IND_A = 5'h0F,
        OP_XFER_A_BASED = 5'h10, OP_XFER_BASED_A = 5'h11,
        OP_SWAP_A_X = 5'h12, OP_SWAP_A_R = 5'h13,
        OP_SWAP_A_SADDR = 5'h14, OP_SWAP_A_SFR = 5'h15,
        OP_SWAP_A_IND = 5'h16, OP_SWAP_A_BASED = 5'h17
    } cdtd_op_e;
    typedef enum logic [2:0] {
        FM_KEEP = 3'h0, FM_CLR = 3'h1, FM_SET = 3'h2,
        FM_RESULT = 3'h3, FM_RESTORE = 3'h4
    } cdtd_fmode_e;
    typedef enum logic [2:0] {
        CK_SADDR = 3'h0, CK_SADDRP = 3'h1, CK_ABS = 3'h2,
        CK_ABS_WORD = 3'h3, CK_CALL = 3'h4
    } cdtd_chk_e;
    typedef struct packed {
        cdtd_op_e    op;
        logic [2:0]  reg_idx;
        logic [1:0]  pair_idx;
        logic [7:0]  imm;
        logic [15:0] addr;
    } cdtd_req_s;
    typedef struct packed {
        logic [1:0]  len;
        logic [3:0]  clocks;
        logic        rd;
        logic        wr;
    } cdtd_info_s;
    typedef struct packed {
        cdtd_chk_e   kind;
        logic [15:0] addr;
        logic [2:0]  bit_num;
        logic [15:0] pc;
        logic [7:0]  branch_offset;
    } cdtd_chk_s;
endpackage

// File: cdtd_tb_top.sv
// Self-checking bench for the data-transfer decode and execute core.
// Assumes cdtd_pkg and cdtd_core are compiled first; the bench stands in
// for the memory bus and answers reads one cycle after each request.
`timescale 1ns/1ps
module cdtd_tb_top;
    import cdtd_pkg::*;

    localparam int LIMIT = 5000;

    logic              clk_sys;
    logic              rst_n;
    logic              req_valid;
    logic              req_ready;
    cdtd_req_s         req;
    logic [7:0]        flags_saved;
    logic              done_q;
    logic [1:0]        len_q;
    logic              err_q;
    logic              mem_req;
    logic              mem_we;
    logic [15:0]       mem_addr;
    logic [7:0]        mem_wdata;
    logic [7:0]        mem_rdata;
    logic [7:0]        acc;
    logic [15:0]       wide_accumulator;
    logic [7:0]        program_status_word;
    cdtd_chk_s         chk;
    logic              chk_ok_q;
    logic [7:0]        bit_mask_q;
    logic [15:0]       branch_target_q;
    logic [7:0]        rd_val;
    logic              mon_mem;
    logic [31:0]       cyc;
    int                fail_count;
    int                n_tests;
    logic [7:0]        eq[$];
    logic [31:0]       tq[$];
    logic [24:0]       mq[$];
    logic [1:0]        lens[24] = '{3, 3, 3, 2, 2, 2, 2, 2, 2, 3, 3, 3,
                                    2, 2, 1, 1, 2, 2, 1, 2, 2, 2, 1, 2};
    logic [4:0]        clks[24] = '{6, 6, 6, 4, 4, 4, 4, 4, 4, 8, 8, 6,
                                    4, 4, 6, 6, 6, 6, 4, 6, 6, 6, 8, 8};
    logic [15:0]       pts[14] = '{16'hFE1F, 16'hFE20, 16'hFE21, 16'hFF1E,
                                   16'hFF1F, 16'hFF20, 16'h003F, 16'h0040,
                                   16'h0041, 16'h007E, 16'h007F, 16'h0080,
                                   16'h0000, 16'hFFFF};

    cdtd_core uut (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .req_valid           (req_valid),
        .req_ready           (req_ready),
        .req                 (req),
        .flags_saved         (flags_saved),
        .done_q              (done_q),
        .len_q               (len_q),
        .err_q               (err_q),
        .mem_req             (mem_req),
        .mem_we              (mem_we),
        .mem_addr            (mem_addr),
        .mem_wdata           (mem_wdata),
        .mem_rdata           (mem_rdata),
        .acc                 (acc),
        .wide_accumulator    (wide_accumulator),
        .program_status_word (program_status_word),
        .chk                 (chk),
        .chk_ok_q            (chk_ok_q),
        .bit_mask_q          (bit_mask_q),
        .branch_target_q     (branch_target_q)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cyc <= 32'h0;
        end else begin
            cyc <= cyc + 32'h1;
            if (cyc == LIMIT) begin
                fail_count++;
                complete_run();
            end
        end
    end

    // Completion watcher: length, refusal and cycles from accept to done.
    always @(posedge clk_sys) begin : done_mon
        logic [7:0]  e;
        logic [31:0] t;
        if (done_q === 1'b1 || err_q === 1'b1) begin
            if (eq.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                e = eq.pop_front();
                t = tq.pop_front();
                check({err_q, err_q ? 2'h0 : len_q, 5'(cyc - t)}, e);
            end
        end
    end

    // Memory stand-in: checks accesses and answers reads one cycle later.
    always @(posedge clk_sys) begin : mem_resp
        logic        hit;
        logic [24:0] m;
        hit = (mem_req === 1'b1) && (mem_we === 1'b0);
        if (mon_mem && mem_req === 1'b1) begin
            m = (mq.size() != 0) ? mq.pop_front() : 25'h1FFFFFF;
            check({mem_we, mem_addr, mem_we ? mem_wdata : 8'h00}, m);
        end
        #1;
        mem_rdata = hit ? rd_val : ~rd_val;
    end

    task automatic issue(input cdtd_op_e op, input logic [2:0] r,
                         input logic [1:0] p, input logic [7:0] imm,
                         input logic [15:0] a, input logic e,
                         input logic [1:0] l, input logic [4:0] n);
        int k;
        req = '{op: op, reg_idx: r, pair_idx: p, imm: imm, addr: a};
        req_valid = 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (req_ready !== 1'b1 && k < 20);
        tq.push_back(cyc);
        eq.push_back({e, l, n});
        #1;
    endtask

    task automatic bad(input cdtd_op_e op, input logic [2:0] r,
                       input logic [1:0] p, input logic [15:0] a);
        issue(op, r, p, 8'h00, a, 1'b1, 2'h0, 5'h1);
    endtask

    task automatic idle_wait(input int n);
        req_valid = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    initial begin : main
        logic [7:0]  v[8];
        logic [15:0] a;
        logic        ok;
        cdtd_chk_s   c;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        chk = '0;
        flags_saved = 8'h00;
        mem_rdata = 8'h00;
        rd_val = 8'h00;
        mon_mem = 1'b0;
        fail_count = 0;
        n_tests = 0;
        void'($urandom(32'h1473a488));
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        flags_saved = 8'($urandom);
        check({req_ready, acc, program_status_word, wide_accumulator},
              {1'b1, 8'h00, 8'h00, 16'h0000});
        $display("test reset done");
        for (int i = 0; i < 24; i++)
            issue(cdtd_op_e'(i), 3'h2, 2'h2, 8'($urandom), 16'hFE20,
                  1'b0, lens[i], clks[i]);
        idle_wait(9);
        $display("test lengths and clocks done");
        bad(OP_XFER_A_R, 3'h1, 2'h2, 16'hFE20);
        bad(OP_XFER_R_A, 3'h1, 2'h2, 16'hFE20);
        bad(OP_SWAP_A_R, 3'h1, 2'h2, 16'hFE20);
        bad(OP_SWAP_A_R, 3'h0, 2'h2, 16'hFE20);
        bad(OP_XFER_A_SADDR, 3'h2, 2'h2, 16'hFE1F);
        bad(OP_XFER_SADDR_IMM, 3'h2, 2'h2, 16'hFF20);
        bad(OP_SWAP_A_SADDR, 3'h2, 2'h2, 16'hFF20);
        bad(OP_XFER_A_IND, 3'h2, 2'h1, 16'hFE20);
        bad(OP_SWAP_A_IND, 3'h2, 2'h0, 16'hFE20);
        issue(OP_SWAP_A_X, 3'h0, 2'h0, 8'h00, 16'h0, 1'b0, 2'h1, 5'h4);
        idle_wait(9);
        $display("test refusals done");
        foreach (v[i]) v[i] = 8'($urandom);
        mon_mem = 1'b1;
        issue(OP_XFER_R_IMM, 3'h1, 2'h0, v[0], 16'h0, 1'b0, 2'h3, 5'h6);
        issue(OP_XFER_R_IMM, 3'h0, 2'h0, v[1], 16'h0, 1'b0, 2'h3, 5'h6);
        idle_wait(6);
        check(wide_accumulator, {v[0], v[1]});
        issue(OP_SWAP_A_X, 3'h2, 2'h0, 8'h00, 16'h0, 1'b0, 2'h1, 5'h4);
        idle_wait(4);
        check(wide_accumulator, {v[1], v[0]});
        issue(OP_XFER_R_IMM, 3'h7, 2'h0, v[2], 16'h0, 1'b0, 2'h3, 5'h6);
        issue(OP_XFER_R_IMM, 3'h6, 2'h0, v[3], 16'h0, 1'b0, 2'h3, 5'h6);
        idle_wait(6);
        rd_val = v[4];
        mq.push_back({1'b0, v[2], v[3], 8'h00});
        mq.push_back({1'b1, v[2], v[3], v[1]});
        issue(OP_SWAP_A_IND, 3'h0, 2'h3, 8'h00, 16'h0, 1'b0, 2'h1, 5'h8);
        idle_wait(8);
        check(acc, v[4]);
        issue(OP_XFER_STAT_IMM, 3'h0, 2'h0, v[5], 16'h0, 1'b0, 2'h3, 5'h6);
        idle_wait(6);
        check(program_status_word, v[5]);
        issue(OP_XFER_A_STAT, 3'h0, 2'h0, 8'h00, 16'h0, 1'b0, 2'h2, 5'h4);
        idle_wait(4);
        check({acc, program_status_word}, {v[5], v[5]});
        a = {v[6], v[7] & 8'hFE};
        rd_val = v[7];
        mq.push_back({1'b0, a, 8'h00});
        issue(OP_XFER_A_ABS, 3'h0, 2'h0, 8'h00, a, 1'b0, 2'h3, 5'h8);
        idle_wait(8);
        check(acc, v[7]);
        mq.push_back({1'b1, ~a, v[7]});
        issue(OP_XFER_ABS_A, 3'h0, 2'h0, 8'h00, ~a, 1'b0, 2'h3, 5'h8);
        idle_wait(8);
        rd_val = v[6];
        mq.push_back({1'b0, 16'hFF12, 8'h00});
        issue(OP_XFER_A_SFR, 3'h0, 2'h0, 8'h00, 16'h0012, 1'b0, 2'h2, 5'h4);
        idle_wait(4);
        check(acc, v[6]);
        mon_mem = 1'b0;
        check(32'(mq.size()), 32'h0);
        $display("test data movement done");
        for (int i = 0; i < 60; i++) begin
            a = pts[$urandom % 14];
            c = '{kind: cdtd_chk_e'($urandom % 5), addr: a,
                  bit_num: 3'($urandom), pc: 16'($urandom),
                  branch_offset: 8'($urandom)};
            chk = c;
            @(posedge clk_sys);
            #1;
            case (c.kind)
                CK_SADDR:    ok = a >= 16'hFE20 && a <= 16'hFF1F;
                CK_SADDRP:   ok = a >= 16'hFE20 && a <= 16'hFF1F && !a[0];
                CK_ABS:      ok = 1'b1;
                CK_ABS_WORD: ok = !a[0];
                default:     ok = a >= 16'h0040 && a <= 16'h007F && !a[0];
            endcase
            check({chk_ok_q, bit_mask_q, branch_target_q},
                  {ok, 8'h01 << c.bit_num, c.pc +
                   {{8{c.branch_offset[7]}}, c.branch_offset}});
        end
        $display("test operand checks done");
        check(32'(eq.size()), 32'h0);
        complete_run();
    end
endmodule
